// >>> src/tpei_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module tpei_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic [AW:0] count_nxt;
  logic in_ready_r;
  wire push = in_valid && in_ready_r;
  wire pop = out_valid && out_ready;

  assign count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);
  assign in_ready = in_ready_r;
  assign out_valid = (count_r != '0);
  assign out_data = mem_r[rd_ptr_r];

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      in_ready_r <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      count_r <= count_nxt;
      in_ready_r <= (count_nxt != (AW+1)'(DEPTH));
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end
endmodule

// >>> src/tpei_pkg.sv
// Constants shared by the transmit payload error inserter.
package tpei_pkg;
  localparam logic [7:0] TPEI_OFS_RATE_CTRL = 8'hEB;
  localparam logic [7:0] TPEI_OFS_CNT_LO = 8'hEC;
  localparam logic [7:0] TPEI_OFS_CNT_HI = 8'hED;
  localparam logic [7:0] TPEI_OFS_LEFT_LO = 8'hEE;
  localparam logic [7:0] TPEI_OFS_LEFT_HI = 8'hEF;
  localparam logic [7:0] TPEI_RST_REG = 8'h00;
  localparam int TPEI_RATE_LSB = 0;
  localparam int TPEI_RATE_W = 4;
  localparam int TPEI_CONT_BIT = 4;
  localparam int TPEI_LOAD_BIT = 7;
  localparam int TPEI_CNT_HI_W = 2;
  localparam int TPEI_CNT_W = 10;
  localparam logic [3:0] TPEI_RATE_OFF = 4'h0;
  localparam logic [4:0] TPEI_RATE_EXP_OFS = 5'h03;
  localparam int TPEI_BITCNT_W = 18;
  localparam int TPEI_FIFO_DEPTH = 32;
  localparam int TPEI_WORD_W = 4;
  localparam int TPEI_W_DATA = 0;
  localparam int TPEI_W_FBIT = 1;
  localparam int TPEI_W_FSTART = 2;
  localparam int TPEI_W_CHAN = 3;
endpackage

// >>> src/tpei_top.sv
// Transmit payload error inserter with its host registers and input FIFO.
`timescale 1ns/1ps
// Notes on behaviour
// R1 - Corrupt only outgoing transmit payload bits.
// R2 - Errors over whole frame or chosen channels.
// R3 - Invert the last bit of each interval.
// R4 - Framing bits never counted nor inverted.
// R5 - New rate takes effect at frame boundary.
// R6 - Rate code k gives 1 in 2^(k+3).
// R7 - Rate zero inserts nothing, even continuous.
// R8 - Continuous mode ignores count, inserts forever.
// R9 - Counted mode inserts loaded count, then stops.
// R10 - Load strobe rise loads count two cycles later.
// R11 - Only rising load strobe loads; host re-arms.
// R12 - Ten-bit count split low and high registers.
// R13 - Count zero gives none; 3FFh gives 1023.
// R14 - Pending error count readable at any time.
// R15 - Host sets rate, then mode and count.
// R16 - Host writes zero to control bits 5,6.
// R17 - Pending count drops per error, stops zero.
// R18 - Per-channel mode: only selected channels count.
module tpei_top
  import tpei_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic per_chan_en,
  input wire logic tx_in_bit,
  input wire logic tx_in_fbit,
  input wire logic tx_in_frame_start,
  input wire logic tx_in_chan_sel,
  input wire logic tx_in_valid,
  output logic tx_in_ready,
  output logic tx_out_bit,
  output logic tx_out_fbit,
  output logic tx_out_frame_start,
  output logic tx_out_err,
  output logic tx_out_valid,
  input wire logic tx_out_ready
);
  import tpei_pkg::*;

  logic [7:0] rate_ctrl_r;
  logic [7:0] cnt_lo_r;
  logic [TPEI_CNT_HI_W-1:0] cnt_hi_r;
  logic [TPEI_CNT_W-1:0] left_r;
  logic load_pend_r;
  logic [TPEI_RATE_W-1:0] act_rate_r;
  logic [TPEI_BITCNT_W-1:0] bitcnt_r;
  logic [7:0] rdata_r;
  logic out_bit_r;
  logic out_fbit_r;
  logic out_fstart_r;
  logic out_err_r;
  logic out_valid_r;

  logic [TPEI_WORD_W-1:0] fifo_word;
  logic fifo_valid;
  logic fifo_ready;

  tpei_fifo #(
    .WIDTH(TPEI_WORD_W),
    .DEPTH(TPEI_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_data({tx_in_chan_sel, tx_in_frame_start, tx_in_fbit, tx_in_bit}),
    .in_valid(tx_in_valid),
    .in_ready(tx_in_ready),
    .out_data(fifo_word),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready)
  );

  wire wr_ctrl = reg_wr && (reg_addr == TPEI_OFS_RATE_CTRL);
  wire wr_lo = reg_wr && (reg_addr == TPEI_OFS_CNT_LO);
  wire wr_hi = reg_wr && (reg_addr == TPEI_OFS_CNT_HI);
  wire load_rise = wr_ctrl && reg_wdata[TPEI_LOAD_BIT] && !rate_ctrl_r[TPEI_LOAD_BIT];
  wire [TPEI_CNT_W-1:0] cnt_val = {cnt_hi_r, cnt_lo_r};
  wire [TPEI_RATE_W-1:0] new_rate = rate_ctrl_r[TPEI_RATE_LSB +: TPEI_RATE_W];
  wire cont_mode = rate_ctrl_r[TPEI_CONT_BIT];

  assign fifo_ready = !out_valid_r || tx_out_ready;
  wire take = fifo_valid && fifo_ready;
  wire w_bit = fifo_word[TPEI_W_DATA];
  wire w_fbit = fifo_word[TPEI_W_FBIT];
  wire w_fstart = fifo_word[TPEI_W_FSTART];
  wire w_chan = fifo_word[TPEI_W_CHAN];

  wire eligible = !w_fbit && (!per_chan_en || w_chan); // R4 R18 R2
  wire [4:0] rate_exp = {1'b0, act_rate_r} + TPEI_RATE_EXP_OFS; // R6
  wire [TPEI_BITCNT_W:0] one_wide = (TPEI_BITCNT_W+1)'(1);
  wire [TPEI_BITCNT_W-1:0] last_idx =
    TPEI_BITCNT_W'((one_wide << rate_exp) - one_wide);
  wire at_last = (bitcnt_r == last_idx); // R3
  wire rate_on = (act_rate_r != TPEI_RATE_OFF); // R7
  wire budget = cont_mode || (left_r != '0); // R8 R9
  wire flip = take && eligible && rate_on && at_last && budget;
  wire frame_edge = take && w_fstart;
  wire [TPEI_BITCNT_W-1:0] bitcnt_adv = at_last ? '0 : bitcnt_r + 1'b1;

  wire [7:0] ctrl_rd = rate_ctrl_r & {1'b1, 2'b00, 5'h1F};
  wire [7:0] rd_mux =
    (reg_addr == TPEI_OFS_RATE_CTRL) ? ctrl_rd :
    (reg_addr == TPEI_OFS_CNT_LO) ? cnt_lo_r :
    (reg_addr == TPEI_OFS_CNT_HI) ? {6'h00, cnt_hi_r} :
    (reg_addr == TPEI_OFS_LEFT_LO) ? left_r[7:0] :
    (reg_addr == TPEI_OFS_LEFT_HI) ? {6'h00, left_r[9:8]} : 8'h00; // R14

  assign reg_rdata = rdata_r;
  assign tx_out_bit = out_bit_r;
  assign tx_out_fbit = out_fbit_r;
  assign tx_out_frame_start = out_fstart_r;
  assign tx_out_err = out_err_r;
  assign tx_out_valid = out_valid_r;

  // Host register file; bits 5 and 6 of the control register are not kept.
  always_ff @(posedge clk) begin
    if (rst) begin
      rate_ctrl_r <= TPEI_RST_REG;
      cnt_lo_r <= TPEI_RST_REG;
      cnt_hi_r <= '0;
      rdata_r <= TPEI_RST_REG;
    end else begin
      if (wr_ctrl) begin
        rate_ctrl_r <= reg_wdata & {1'b1, 2'b00, 5'h1F}; // R16
      end
      if (wr_lo) begin
        cnt_lo_r <= reg_wdata; // R12
      end
      if (wr_hi) begin
        cnt_hi_r <= reg_wdata[TPEI_CNT_HI_W-1:0]; // R12
      end
      if (reg_rd) begin
        rdata_r <= rd_mux; // R14
      end
    end
  end

  // Pending error counter; a load wins over a decrement.
  always_ff @(posedge clk) begin
    if (rst) begin
      load_pend_r <= 1'b0;
      left_r <= '0;
    end else begin
      load_pend_r <= load_rise; // R10 R11
      if (load_pend_r) begin
        left_r <= cnt_val; // R10 R13
      end else if (flip && !cont_mode) begin
        left_r <= left_r - 1'b1; // R17
      end
    end
  end

  // A changed rate is taken up at a frame start and the interval restarts with it.
  always_ff @(posedge clk) begin
    if (rst) begin
      act_rate_r <= TPEI_RATE_OFF;
      bitcnt_r <= '0;
    end else if (frame_edge && (act_rate_r != new_rate)) begin
      act_rate_r <= new_rate; // R5
      bitcnt_r <= '0;
    end else if (take && eligible && rate_on) begin
      bitcnt_r <= bitcnt_adv; // R3 R4
    end
  end

  // Output stage of the transmit stream.
  always_ff @(posedge clk) begin
    if (rst) begin
      out_bit_r <= 1'b0;
      out_fbit_r <= 1'b0;
      out_fstart_r <= 1'b0;
      out_err_r <= 1'b0;
      out_valid_r <= 1'b0;
    end else if (fifo_ready) begin
      out_valid_r <= fifo_valid;
      out_bit_r <= w_bit ^ flip; // R1
      out_fbit_r <= w_fbit;
      out_fstart_r <= w_fstart;
      out_err_r <= flip;
    end
  end

  property p_fbit_clean;
    @(posedge clk) disable iff (rst)
    out_valid_r && out_fbit_r |-> !out_err_r;
  endproperty
  a_fbit_clean: assert property (p_fbit_clean) else $error("framing bit inverted"); // R4

  property p_rate_zero;
    @(posedge clk) disable iff (rst)
    act_rate_r == TPEI_RATE_OFF && fifo_ready |=> !out_err_r;
  endproperty
  a_rate_zero: assert property (p_rate_zero) else $error("error with rate off"); // R7

  property p_load;
    @(posedge clk) disable iff (rst)
    load_rise |=> load_pend_r ##1 (left_r == $past(cnt_val));
  endproperty
  a_load: assert property (p_load) else $error("count not loaded"); // R10

  property p_no_reload;
    @(posedge clk) disable iff (rst)
    wr_ctrl && rate_ctrl_r[TPEI_LOAD_BIT] |=> !load_pend_r;
  endproperty
  a_no_reload: assert property (p_no_reload) else $error("load without rising edge"); // R11

  property p_decrement;
    @(posedge clk) disable iff (rst)
    flip && !cont_mode && !load_pend_r |=> left_r == $past(left_r) - 1'b1;
  endproperty
  a_decrement: assert property (p_decrement) else $error("pending count not reduced"); // R17

  property p_stop;
    @(posedge clk) disable iff (rst)
    !cont_mode && left_r == '0 |-> !flip;
  endproperty
  a_stop: assert property (p_stop) else $error("error after count ran out"); // R9

  property p_last_bit;
    @(posedge clk) disable iff (rst)
    flip |-> bitcnt_r == last_idx && last_idx[2:0] == 3'h7;
  endproperty
  a_last_bit: assert property (p_last_bit) else $error("inverted bit not last"); // R3

  property p_frame_rate;
    @(posedge clk) disable iff (rst)
    $changed(act_rate_r) |-> $past(frame_edge);
  endproperty
  a_frame_rate: assert property (p_frame_rate) else $error("rate changed mid frame"); // R5

  property p_chan;
    @(posedge clk) disable iff (rst)
    flip && per_chan_en |-> w_chan && !w_fbit;
  endproperty
  a_chan: assert property (p_chan) else $error("unselected channel inverted"); // R18

  property p_cont;
    @(posedge clk) disable iff (rst)
    take && eligible && rate_on && at_last && cont_mode |=> out_err_r;
  endproperty
  a_cont: assert property (p_cont) else $error("continuous error missed"); // R8

  property p_read_left;
    @(posedge clk) disable iff (rst)
    reg_rd && reg_addr == TPEI_OFS_LEFT_LO |=> reg_rdata == $past(left_r[7:0]);
  endproperty
  a_read_left: assert property (p_read_left) else $error("wrong pending count read"); // R14

  property p_hold;
    @(posedge clk) disable iff (rst)
    out_valid_r && !tx_out_ready |=> out_valid_r && $stable(out_bit_r);
  endproperty
  a_hold: assert property (p_hold) else $error("output changed while stalled"); // R1

  property p_flags_pass;
    @(posedge clk) disable iff (rst)
    take |=> out_fstart_r == $past(w_fstart) && out_fbit_r == $past(w_fbit);
  endproperty
  a_flags_pass: assert property (p_flags_pass) else $error("frame flags altered"); // R1

  property p_bit_pass;
    @(posedge clk) disable iff (rst)
    take && !flip |=> out_bit_r == $past(w_bit);
  endproperty
  a_bit_pass: assert property (p_bit_pass) else $error("clean bit altered"); // R1

  property p_zero_load;
    @(posedge clk) disable iff (rst)
    load_pend_r && cnt_val == '0 |=> left_r == '0;
  endproperty
  a_zero_load: assert property (p_zero_load) else $error("zero count not loaded"); // R13

  property p_cont_keep;
    @(posedge clk) disable iff (rst)
    cont_mode && !load_pend_r |=> $stable(left_r);
  endproperty
  a_cont_keep: assert property (p_cont_keep) else $error("count moved in continuous mode"); // R8

  property p_fbit_hold;
    @(posedge clk) disable iff (rst)
    take && w_fbit && !frame_edge |=> $stable(bitcnt_r);
  endproperty
  a_fbit_hold: assert property (p_fbit_hold) else $error("framing bit counted"); // R4

  property p_wrap;
    @(posedge clk) disable iff (rst)
    take && eligible && rate_on && at_last && !frame_edge |=> bitcnt_r == '0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("interval did not restart"); // R3

  property p_rate_restart;
    @(posedge clk) disable iff (rst)
    frame_edge && act_rate_r != new_rate |=> bitcnt_r == '0 && act_rate_r == $past(new_rate);
  endproperty
  a_rate_restart: assert property (p_rate_restart) else $error("rate not taken at frame"); // R5

  property p_rdata_hold;
    @(posedge clk) disable iff (rst)
    !reg_rd |=> $stable(reg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without read"); // R14
endmodule

// >>> test/tpei_sink.sv
// Downstream sink model that takes output words, promptly, with random stalls, or not at all.
`timescale 1ns/1ps
module tpei_sink (
  input wire logic clk,
  input wire logic [1:0] mode,
  output logic ready
);
  integer seed = 32'h4b563172;
  initial ready = 1'b1;
  always @(posedge clk) begin
    ready <= (mode == 2'h0) || (mode == 2'h1 && $random(seed) % 2 != 0);
  end
endmodule

// >>> test/tpei_top_bench.sv
// Self-checking bench for the transmit payload error inserter.
`timescale 1ns/1ps
module tpei_top_bench;
  import tpei_pkg::*;
  logic clk, rst, reg_wr, reg_rd, pce, ib, ifb, ifs, ich, iv, ir;
  logic ob, ofb, ofs, oe, ov, ordy, cont, fe;
  logic [7:0] ra, rw, rr, d;
  logic [1:0] smode;
  logic [3:0] crate, arate;
  logic [9:0] left;
  logic [18:0] cnt;
  logic [3:0] expq[$];
  integer seed = 32'h4b563172;
  int n_errors = 0;
  int cmp_count = 0;
  int nacc;
  tpei_top uut (.clk(clk), .rst(rst), .reg_addr(ra), .reg_wdata(rw), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(rr), .per_chan_en(pce), .tx_in_bit(ib), .tx_in_fbit(ifb),
    .tx_in_frame_start(ifs), .tx_in_chan_sel(ich), .tx_in_valid(iv), .tx_in_ready(ir),
    .tx_out_bit(ob), .tx_out_fbit(ofb), .tx_out_frame_start(ofs), .tx_out_err(oe),
    .tx_out_valid(ov), .tx_out_ready(ordy));
  tpei_sink sink (.clk(clk), .mode(smode), .ready(ordy));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(string nm, logic [9:0] seen, logic [9:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] v);
    ra <= a;
    rw <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(logic [7:0] a, output logic [7:0] v);
    ra <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    v = rr;
  endtask
  function automatic logic ref_err(logic f, logic s, logic c);
    logic e = 1'b0;
    if (s) begin
      if (crate != arate) cnt = 0;
      arate = crate;
    end
    if (!f && (c || !pce) && arate != 4'h0) begin
      cnt++;
      if (cnt == 19'(1) << (arate + 3)) begin
        cnt = 0;
        e = cont || left != 10'h000;
        if (e && !cont) left--;
      end
    end
    return e;
  endfunction
  task automatic push(logic b, logic f, logic s, logic c, logic last);
    logic e;
    ib <= b;
    ifb <= f;
    ifs <= s;
    ich <= c;
    iv <= 1'b1;
    @(posedge clk);
    while (!ir) @(posedge clk);
    e = ref_err(f, s, c);
    expq.push_back({b ^ e, f, s, e});
    if (last) iv <= 1'b0;
  endtask
  task automatic drain;
    for (int i = 0; i < 400 && expq.size() != 0; i++) @(posedge clk);
    chk("queue_empty", 10'(expq.size()), 10'h000);
  endtask
  task automatic frame(int n, logic pc, logic st);
    if (st) push(1'($random(seed)), 1'b1, 1'b1, 1'b1, 1'b0);
    for (int i = 1; i <= n; i++)
      push(1'($random(seed)), 1'b0, 1'b0, pc ? 1'($random(seed)) : 1'b1, i == n);
    drain;
  endtask
  task automatic chk_left;
    rd(TPEI_OFS_LEFT_LO, d);
    chk("left_lo", d, left[7:0]);
    rd(TPEI_OFS_LEFT_HI, d);
    chk("left_hi", d, {8'h00, left[9:8]});
  endtask
  task automatic cfg(logic [3:0] r, logic c, logic [9:0] n);
    wr(TPEI_OFS_RATE_CTRL, {3'h0, c, r});
    wr(TPEI_OFS_CNT_LO, n[7:0]);
    wr(TPEI_OFS_CNT_HI, {6'h00, n[9:8]});
    crate = r;
    cont = c;
    if (!c) begin
      wr(TPEI_OFS_RATE_CTRL, {3'h4, c, r});
      left = n;
    end
    repeat (2) @(posedge clk);
  endtask
  always @(posedge clk) begin
    if (!rst && ov && ordy)
      chk("out_word", {6'h00, ob, ofb, ofs, oe}, expq.size() ? expq.pop_front() : 4'hF);
  end
  initial begin
    rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; ra = 8'h00; rw = 8'h00; pce = 1'b0;
    ib = 1'b0; ifb = 1'b0; ifs = 1'b0; ich = 1'b0; iv = 1'b0; smode = 2'h1;
    crate = 4'h0; arate = 4'h0; cont = 1'b0; left = 10'h000; cnt = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int a = 8'hEB; a <= 8'hEF; a++) begin
      rd(8'(a), d);
      chk("reset_reg", d, 10'h000);
    end
    $display("test reset done");
    cfg(4'h1, 1'b0, 10'h3FF);
    chk_left;
    cfg(4'h1, 1'b0, 10'h002);
    chk_left;
    frame(40, 1'b0, 1'b1);
    chk_left;
    frame(40, 1'b0, 1'b1);
    wr(TPEI_OFS_CNT_LO, 8'h05);
    wr(TPEI_OFS_RATE_CTRL, 8'h81);
    repeat (2) @(posedge clk);
    chk_left;
    rd(TPEI_OFS_RATE_CTRL, d);
    chk("ctrl_readback", d, 10'h081);
    cfg(4'h1, 1'b0, 10'h000);
    frame(40, 1'b0, 1'b1);
    $display("test counted mode done");
    cfg(4'h0, 1'b1, 10'h000);
    frame(40, 1'b0, 1'b1);
    cfg(4'h1, 1'b1, 10'h000);
    frame(20, 1'b0, 1'b1);
    wr(TPEI_OFS_RATE_CTRL, 8'h12);
    crate = 4'h2;
    frame(20, 1'b0, 1'b0);
    frame(70, 1'b0, 1'b1);
    pce <= 1'b1;
    frame(80, 1'b1, 1'b1);
    pce <= 1'b0;
    $display("test continuous and channel modes done");
    for (int k = 1; k < 16; k++) begin
      cfg(4'(k), 1'b1, 10'h000);
      frame(70, 1'b0, 1'b1);
    end
    $display("test rate codes done");
    wr(TPEI_OFS_LEFT_LO, 8'h55);
    chk_left;
    rd(8'h10, d);
    chk("unmapped_read", d, 10'h000);
    smode <= 2'h2;
    repeat (3) @(posedge clk);
    nacc = 0;
    ib <= 1'b1;
    ifb <= 1'b0;
    ifs <= 1'b0;
    ich <= 1'b1;
    iv <= 1'b1;
    repeat (40) begin
      @(posedge clk);
      if (ir) begin
        fe = ref_err(1'b0, 1'b0, 1'b1);
        expq.push_back({~fe, 2'b00, fe});
        nacc++;
      end
    end
    iv <= 1'b0;
    chk("fill_ready", {9'h000, ir}, 10'h000);
    chk("fill_count", {9'h000, nacc >= TPEI_FIFO_DEPTH}, 10'h001);
    smode <= 2'h1;
    drain;
    $display("test buffer fill done");
    print_verdict;
  end
  initial begin
    #(25 * 60000);
    n_errors++;
    print_verdict;
  end
endmodule
